// [cpg_pkg.sv]
package cpg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [7:0] LANE_POWER_AND_POLARITY_IDX = 8'h30;
  localparam logic [7:0] CH13_GAIN_OFFSET_PRIMARY_IDX = 8'h31;
  localparam logic [7:0] CH13_OFFSET_SECONDARY_IDX = 8'h32;
  localparam logic [7:0] GLOBAL_ENABLE_IDX = 8'h34;
  localparam logic [7:0] BLOCK_STATUS_IDX = 8'h35;

  // Reset values
  localparam logic [15:0] LANE_POWER_AND_POLARITY_RST = 16'h0000;
  localparam logic [15:0] CH13_GAIN_OFFSET_PRIMARY_RST = 16'h0000;
  localparam logic [15:0] CH13_OFFSET_SECONDARY_RST = 16'h0000;
  localparam logic [1:0] GLOBAL_ENABLE_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the power and polarity register
  localparam int DIG_PD_LSB = 12;
  localparam int SER_PD_LSB = 8;
  localparam int ANA_PD_LSB = 4;
  localparam int FLIP_LSB = 0;
  localparam int LANES = 4;

  // Field positions of the lane 13 registers
  localparam int GAIN_MSB = 15;
  localparam int GAIN_LSB = 11;
  localparam int OFFS_MSB = 9;
  localparam int OFFS_LSB = 0;
  localparam logic [15:0] PRIMARY_MASK = 16'hFBFF;
  localparam logic [15:0] SECONDARY_MASK = 16'h03FF;

  // Global enable field positions
  localparam int GAIN_EN_BIT = 0;
  localparam int OFFS_EN_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Sample datapath sizes
  localparam int SAMPLE_W = 14;
  localparam int OFFS_W = 10;
  localparam int GAIN_FRAC = 10;
  localparam int GAIN_W = 12;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 14'sh1FFF;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = -14'sh2000;

  // Linear factor for N steps of 0.2 dB, scaled by 2**10
  function automatic logic [11:0] gain_factor(input logic [4:0] n);
    logic [11:0] f;
    f = 12'h400;
    unique case (n)
      5'h00: f = 12'h400;
      5'h01: f = 12'h418;
      5'h02: f = 12'h430;
      5'h03: f = 12'h449;
      5'h04: f = 12'h463;
      5'h05: f = 12'h47D;
      5'h06: f = 12'h498;
      5'h07: f = 12'h4B3;
      5'h08: f = 12'h4CF;
      5'h09: f = 12'h4EC;
      5'h0A: f = 12'h509;
      5'h0B: f = 12'h527;
      5'h0C: f = 12'h546;
      5'h0D: f = 12'h565;
      5'h0E: f = 12'h585;
      5'h0F: f = 12'h5A6;
      5'h10: f = 12'h5C8;
      5'h11: f = 12'h5EB;
      5'h12: f = 12'h60E;
      5'h13: f = 12'h632;
      5'h14: f = 12'h657;
      5'h15: f = 12'h67D;
      5'h16: f = 12'h6A3;
      5'h17: f = 12'h6CB;
      5'h18: f = 12'h6F4;
      5'h19: f = 12'h71D;
      5'h1A: f = 12'h747;
      5'h1B: f = 12'h773;
      5'h1C: f = 12'h79F;
      5'h1D: f = 12'h7CD;
      5'h1E: f = 12'h7FB;
      5'h1F: f = 12'h82B;
    endcase
    return f;
  endfunction

  // Bus handshake states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } cpg_bus_state_t;

endpackage

// [cpg_lane_stage.sv]
`timescale 1ns/10ps
`default_nettype none

module cpg_lane_stage (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [cpg_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic valid_i,
  input wire logic pattern_i,
  input wire logic flip_i,
  input wire logic dig_pd_i,
  output logic [cpg_pkg::SAMPLE_W-1:0] sample_o,
  output logic valid_o
);

  logic [cpg_pkg::SAMPLE_W-1:0] sample_reg; // Registered lane data
  logic [cpg_pkg::SAMPLE_W-1:0] sample_next;
  logic valid_reg; // Registered lane valid
  logic valid_next;

  //////////////////////////////////////////////////////////////////////////
  // Next lane value
  always_comb
  begin
    sample_next = sample_i;
    valid_next = valid_i;
    if (dig_pd_i)
    begin
      // Digital block off, lane goes quiet
      sample_next = '0;
      valid_next = 1'b0;
    end
    else if (flip_i && !pattern_i)
    begin
      // Only real samples are inverted, patterns pass
      sample_next = ~sample_i;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sample_reg <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      sample_reg <= sample_next;
      valid_reg <= valid_next;
    end
  end

  assign sample_o = sample_reg;
  assign valid_o = valid_reg;

endmodule
`default_nettype wire

// [cpg_regs.sv]
// What this block does
// - Bits 15..12 power down digital lanes 12..9
// - Bits 11..8 power down serial outputs 12..9
// - Bits 7..4 power down analog lanes 12..9
// - Bits 3..0 invert sample data lanes 12..9
// - Inversion never touches test-pattern data
// - All these bits reset to zero, normal
// - Gain enabled: lane 13 gain N x 0.2dB
// - Offset is 10-bit two's complement, 14-bit LSB
// - Offset added only while offset enable set
`timescale 1ns/10ps
`default_nettype none

module cpg_regs (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0][cpg_pkg::SAMPLE_W-1:0] lane_sample_i,
  input wire logic [3:0] lane_valid_i,
  input wire logic [3:0] lane_pattern_i,
  output logic [3:0][cpg_pkg::SAMPLE_W-1:0] lane_sample_o,
  output logic [3:0] lane_valid_o,
  output logic [3:0] digital_powerdown_o,
  output logic [3:0] serial_out_powerdown_o,
  output logic [3:0] analog_powerdown_o,
  input wire logic [cpg_pkg::SAMPLE_W-1:0] lane13_sample_i,
  input wire logic lane13_valid_i,
  input wire logic lane13_pattern_i,
  output logic [cpg_pkg::SAMPLE_W-1:0] lane13_sample_o,
  output logic lane13_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] power_reg; // Power and polarity
  logic [15:0] power_next;
  logic [15:0] primary_reg; // Lane 13 gain and offset
  logic [15:0] primary_next;
  logic [15:0] secondary_reg; // Lane 13 offset copy
  logic [15:0] secondary_next;
  logic [1:0] enable_reg; // Global gain and offset enables
  logic [1:0] enable_next;

  // Bus handshake state
  cpg_pkg::cpg_bus_state_t state_reg; // Handshake phase
  cpg_pkg::cpg_bus_state_t state_next;
  logic wait_reg; // Registered waitrequest
  logic wait_next;
  logic [31:0] rdata_reg; // Registered read data
  logic [31:0] rdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Lane 13 datapath sizes
  localparam int PROD_W = cpg_pkg::SAMPLE_W + cpg_pkg::GAIN_W + 1;
  localparam int SCALED_W = PROD_W - cpg_pkg::GAIN_FRAC;
  localparam int SUM_W = SCALED_W + 1;

  // Lane 13 datapath state
  logic signed [SCALED_W-1:0] scaled_reg; // Sample after gain
  logic signed [SCALED_W-1:0] scaled_next;
  logic scaled_valid_reg; // Valid beside the scaled sample
  logic scaled_valid_next;
  logic scaled_pattern_reg; // Pattern flag beside it
  logic scaled_pattern_next;
  logic [cpg_pkg::SAMPLE_W-1:0] out13_reg; // Lane 13 output sample
  logic [cpg_pkg::SAMPLE_W-1:0] out13_next;
  logic out13_valid_reg; // Lane 13 output valid
  logic out13_valid_next;

  // Lane 13 arithmetic helpers
  logic signed [cpg_pkg::SAMPLE_W-1:0] in13_s; // Input as signed
  logic signed [cpg_pkg::GAIN_W:0] factor_s; // Gain factor, positive
  logic signed [PROD_W-1:0] product_s; // Full product
  logic signed [SUM_W-1:0] offset_s; // Offset, sign extended
  logic signed [SUM_W-1:0] sum_s; // Scaled sample plus offset

  // Decoded request
  logic hit_power; // Address selects power register
  logic hit_primary; // Address selects gain and offset
  logic hit_secondary; // Address selects offset copy
  logic hit_enable; // Address selects global enables
  logic wr_accept; // Write completes this edge
  logic [15:0] read_word; // Selected register contents

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into a register
  function automatic logic [15:0] merge16(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [1:0] be
  );
    logic [15:0] m;
    m = old_v;
    // Low byte only when its enable is set
    if (be[0])
    begin
      m[7:0] = new_v[7:0];
    end
    // High byte only when its enable is set
    if (be[1])
    begin
      m[15:8] = new_v[15:8];
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by reads and writes
  always_comb
  begin
    hit_power = (avs_address_i == cpg_pkg::LANE_POWER_AND_POLARITY_IDX);
    hit_primary = (avs_address_i == cpg_pkg::CH13_GAIN_OFFSET_PRIMARY_IDX);
    hit_secondary = (avs_address_i == cpg_pkg::CH13_OFFSET_SECONDARY_IDX);
    hit_enable = (avs_address_i == cpg_pkg::GLOBAL_ENABLE_IDX);
    // A write lands only in the cycle waitrequest is low
    wr_accept = (state_reg == cpg_pkg::ST_ACK) && avs_write_i;
  end

  // Read multiplexer, unmapped words read as zero
  always_comb
  begin
    read_word = 16'h0000;
    if (hit_power)
    begin
      read_word = power_reg;
    end
    else if (hit_primary)
    begin
      read_word = primary_reg;
    end
    else if (hit_secondary)
    begin
      read_word = secondary_reg;
    end
    else if (hit_enable)
    begin
      read_word = {14'h0000, enable_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake: request seen, then one cycle with waitrequest low
  always_comb
  begin
    state_next = state_reg;
    wait_next = wait_reg;
    rdata_next = rdata_reg;
    unique case (state_reg)
      cpg_pkg::ST_IDLE:
      begin
        // Answer comes one cycle after the request is seen
        if (avs_read_i || avs_write_i)
        begin
          state_next = cpg_pkg::ST_ACK;
          wait_next = 1'b0;
          // Read data captured now, stands through the answer cycle
          if (avs_read_i)
          begin
            rdata_next = {16'h0000, read_word};
          end
        end
      end
      cpg_pkg::ST_ACK:
      begin
        // Answer given, back to waiting
        state_next = cpg_pkg::ST_IDLE;
        wait_next = 1'b1;
      end
      default:
      begin
        // Illegal code, recover to idle
        state_next = cpg_pkg::ST_IDLE;
        wait_next = 1'b1;
      end
    endcase
  end

  // Handshake registers
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= cpg_pkg::ST_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, unused bits kept at zero
  always_comb
  begin
    power_next = power_reg;
    primary_next = primary_reg;
    secondary_next = secondary_reg;
    enable_next = enable_reg;
    if (wr_accept)
    begin
      // Power and polarity bits, all writable
      if (hit_power)
      begin
        power_next = merge16(power_reg, avs_writedata_i[15:0],
          avs_byteenable_i[1:0]);
      end
      // Gain and offset, bit 10 forced low
      if (hit_primary)
      begin
        primary_next = merge16(primary_reg, avs_writedata_i[15:0],
          avs_byteenable_i[1:0]) & cpg_pkg::PRIMARY_MASK;
      end
      // Offset copy, upper bits forced low
      if (hit_secondary)
      begin
        secondary_next = merge16(secondary_reg, avs_writedata_i[15:0],
          avs_byteenable_i[1:0]) & cpg_pkg::SECONDARY_MASK;
      end
      // Global enables live in the low byte
      if (hit_enable && avs_byteenable_i[0])
      begin
        enable_next = avs_writedata_i[1:0];
      end
    end
  end

  // Register bank, everything clears to normal operation
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      power_reg <= cpg_pkg::LANE_POWER_AND_POLARITY_RST;
      primary_reg <= cpg_pkg::CH13_GAIN_OFFSET_PRIMARY_RST;
      secondary_reg <= cpg_pkg::CH13_OFFSET_SECONDARY_RST;
      enable_reg <= cpg_pkg::GLOBAL_ENABLE_RST;
    end
    else
    begin
      power_reg <= power_next;
      primary_reg <= primary_next;
      secondary_reg <= secondary_next;
      enable_reg <= enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lanes 9 to 12, index 0 is lane 9
  genvar g;
  generate
    for (g = 0; g < cpg_pkg::LANES; g++)
    begin : g_lane
      cpg_lane_stage u_stage (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .sample_i(lane_sample_i[g]),
        .valid_i(lane_valid_i[g]),
        .pattern_i(lane_pattern_i[g]),
        .flip_i(power_reg[cpg_pkg::FLIP_LSB + g]),
        .dig_pd_i(power_reg[cpg_pkg::DIG_PD_LSB + g]),
        .sample_o(lane_sample_o[g]),
        .valid_o(lane_valid_o[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Lane 13 first stage: gain, patterns pass untouched
  always_comb
  begin
    in13_s = lane13_sample_i;
    factor_s = {1'b0, cpg_pkg::gain_factor(
      primary_reg[cpg_pkg::GAIN_MSB:cpg_pkg::GAIN_LSB])};
    product_s = in13_s * factor_s;
    // Unity path when gain is off, sign extended
    scaled_next = SCALED_W'(in13_s);
    if (enable_reg[cpg_pkg::GAIN_EN_BIT] && !lane13_pattern_i)
    begin
      // Drop the fraction bits of the factor
      scaled_next = product_s[PROD_W-1:cpg_pkg::GAIN_FRAC];
    end
    scaled_valid_next = lane13_valid_i;
    scaled_pattern_next = lane13_pattern_i;
  end

  // Lane 13 second stage: offset and saturation
  always_comb
  begin
    offset_s = '0;
    if (enable_reg[cpg_pkg::OFFS_EN_BIT] && !scaled_pattern_reg)
    begin
      // Ten-bit two's complement, one step per sample LSB
      offset_s = {{(SUM_W - cpg_pkg::OFFS_W){primary_reg[cpg_pkg::OFFS_MSB]}},
        primary_reg[cpg_pkg::OFFS_MSB:cpg_pkg::OFFS_LSB]};
    end
    sum_s = {scaled_reg[SCALED_W-1], scaled_reg} + offset_s;
    out13_next = sum_s[cpg_pkg::SAMPLE_W-1:0];
    // Clip instead of wrapping at full scale
    if (sum_s > SUM_W'(cpg_pkg::SAMPLE_MAX))
    begin
      out13_next = cpg_pkg::SAMPLE_MAX;
    end
    else if (sum_s < SUM_W'(cpg_pkg::SAMPLE_MIN))
    begin
      out13_next = cpg_pkg::SAMPLE_MIN;
    end
    out13_valid_next = scaled_valid_reg;
  end

  // Lane 13 pipeline registers
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scaled_reg <= '0;
      scaled_valid_reg <= 1'b0;
      scaled_pattern_reg <= 1'b0;
      out13_reg <= '0;
      out13_valid_reg <= 1'b0;
    end
    else
    begin
      scaled_reg <= scaled_next;
      scaled_valid_reg <= scaled_valid_next;
      scaled_pattern_reg <= scaled_pattern_next;
      out13_reg <= out13_next;
      out13_valid_reg <= out13_valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a register
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  // Power controls taken directly from the register bits
  assign digital_powerdown_o =
    power_reg[cpg_pkg::DIG_PD_LSB +: cpg_pkg::LANES];
  assign serial_out_powerdown_o =
    power_reg[cpg_pkg::SER_PD_LSB +: cpg_pkg::LANES];
  assign analog_powerdown_o =
    power_reg[cpg_pkg::ANA_PD_LSB +: cpg_pkg::LANES];
  // Lane 13 result
  assign lane13_sample_o = out13_reg;
  assign lane13_valid_o = out13_valid_reg;

  // The offset copy is only kept for software; the datapath reads
  // the primary copy, so a mismatch between the two is not caught.

endmodule
`default_nettype wire

// [cpg_regs_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module cpg_regs_sva (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire logic [3:0] digital_powerdown_o,
  input wire logic [3:0] serial_out_powerdown_o,
  input wire logic [3:0] analog_powerdown_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Accepted full-word write to the power register
  sequence s_wr;
    avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h30 &&
      avs_byteenable_i == 4'hF;
  endsequence
  sequence s_idle;
    !(avs_write_i && !avs_waitrequest_o);
  endsequence
  property p_dig;
    s_wr |=> digital_powerdown_o == $past(avs_writedata_i[15:12]);
  endproperty
  property p_ser;
    s_wr |=> serial_out_powerdown_o == $past(avs_writedata_i[11:8]);
  endproperty
  property p_ana;
    s_wr |=> analog_powerdown_o == $past(avs_writedata_i[7:4]);
  endproperty
  property p_hold_dig;
    s_idle |=> $stable(digital_powerdown_o);
  endproperty
  property p_hold_ser;
    s_idle |=> $stable(serial_out_powerdown_o);
  endproperty
  property p_hold_ana;
    s_idle |=> $stable(analog_powerdown_o);
  endproperty
  property p_rd_ans;
    avs_read_i |-> ##[0:8] !avs_waitrequest_o;
  endproperty
  property p_wr_ans;
    avs_write_i |-> ##[0:8] !avs_waitrequest_o;
  endproperty
  a_dig: assert property (p_dig) else $error("dig pd");
  a_ser: assert property (p_ser) else $error("ser pd");
  a_ana: assert property (p_ana) else $error("ana pd");
  a_hold_dig: assert property (p_hold_dig) else $error("dig hold");
  a_hold_ser: assert property (p_hold_ser) else $error("ser hold");
  a_hold_ana: assert property (p_hold_ana) else $error("ana hold");
  a_rd_ans: assert property (p_rd_ans) else $error("no rd ans");
  a_wr_ans: assert property (p_wr_ans) else $error("no wr ans");
endmodule
bind cpg_regs cpg_regs_sva u_sva (.*);
`default_nettype wire

// [cpg_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module cpg_regs_tb;
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, avs_read_i = 1'b0;
  logic avs_write_i = 1'b0, avs_waitrequest_o, lane13_valid_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
  logic [3:0] avs_byteenable_i = 4'hF, lane_valid_i = 4'hF;
  logic [3:0] lane_pattern_i = 4'h0, lane_valid_o, digital_powerdown_o;
  logic [3:0] serial_out_powerdown_o, analog_powerdown_o;
  logic [3:0][13:0] lane_sample_i = '0, lane_sample_o;
  logic [13:0] lane13_sample_i = 14'h0064, lane13_sample_o;
  logic lane13_pattern_i = 1'b0, lane13_valid_o;
  logic [15:0] rv;
  int err_total = 0, n_checks = 0, cyc = 0;
  cpg_regs dut (.*);
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One Avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
    rv = avs_readdata_o[15:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic t_pd();
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, 8'h30 + 8'(i), 16'h0000);
      chk("reset", rv, 16'h0000);
    end
    chk("pd0", 16'({digital_powerdown_o, serial_out_powerdown_o,
      analog_powerdown_o}), 16'h0000);
    bus(1'b1, 8'h30, 16'hA5C3);
    bus(1'b0, 8'h30, 16'h0000);
    chk("pwr", rv, 16'hA5C3);
    chk("dig", 16'(digital_powerdown_o), 16'hA);
    chk("ser", 16'(serial_out_powerdown_o), 16'h5);
    chk("ana", 16'(analog_powerdown_o), 16'hC);
    chk("lvalid", 16'(lane_valid_o), 16'h0005);
    bus(1'b0, 8'h00, 16'h0000);
  endtask
  task automatic t_data();
    bus(1'b1, 8'h30, 16'h0001);
    lane_sample_i <= {4{14'h0123}};
    repeat (12) @(posedge sys_clk_i);
    chk("flip", 16'(lane_sample_o[0]), 16'h3EDC);
    chk("keep", 16'(lane_sample_o[1]), 16'h0123);
    lane_pattern_i <= 4'hF;
    repeat (12) @(posedge sys_clk_i);
    chk("pat", 16'(lane_sample_o[0]), 16'h0123);
    bus(1'b1, 8'h31, 16'h03FF);
    bus(1'b1, 8'h32, 16'h03FF);
    bus(1'b1, 8'h34, 16'h0002);
    repeat (12) @(posedge sys_clk_i);
    chk("offs", 16'(lane13_sample_o), 16'h0063);
    bus(1'b1, 8'h34, 16'h0000);
    repeat (12) @(posedge sys_clk_i);
    chk("nooffs", 16'(lane13_sample_o), 16'h0064);
    chk("v13", 16'(lane13_valid_o), 16'h0001);
    bus(1'b1, 8'h31, 16'h2800);
    bus(1'b1, 8'h32, 16'h0000);
    bus(1'b1, 8'h34, 16'h0001);
    repeat (12) @(posedge sys_clk_i);
    chk("gain", 16'(lane13_sample_o), 16'h0070);
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    t_pd();
    t_data();
    end_of_test();
  end
endmodule
`default_nettype wire
